/* File: bpcm_pkg.sv */
// Shared constants for the bit, pointer and code-byte move executor
package bpcm_pkg;
	// Opcodes and decode masks
	localparam logic [7:0] BPCM_OP_IND_STORE = 8'h76;
	localparam logic [7:0] BPCM_OP_IND_MASK = 8'hFE;
	localparam logic [7:0] BPCM_OP_BIT_TO_C = 8'hA2;
	localparam logic [7:0] BPCM_OP_C_TO_BIT = 8'h92;
	localparam logic [7:0] BPCM_OP_DP_LOAD = 8'h90;
	localparam logic [7:0] BPCM_OP_CODE_DP = 8'h93;
	localparam logic [7:0] BPCM_OP_CODE_PC = 8'h83;
	// Machine cycles per instruction, counted from the start pulse
	localparam logic [1:0] BPCM_CYC_IND_STORE = 2'h1;
	localparam logic [1:0] BPCM_CYC_BIT_TO_C = 2'h1;
	localparam logic [1:0] BPCM_CYC_C_TO_BIT = 2'h2;
	localparam logic [1:0] BPCM_CYC_DP_LOAD = 2'h2;
	localparam logic [1:0] BPCM_CYC_CODE = 2'h2;
	// Instruction lengths in bytes
	localparam logic [15:0] BPCM_LEN_ONE = 16'h0001;
	// Values after reset
	localparam logic [15:0] BPCM_DP_RESET = 16'h0000;
	localparam logic [7:0] BPCM_BYTE_RESET = 8'h00;
	localparam logic [15:0] BPCM_ADDR_RESET = 16'h0000;
	// Executor states
	typedef enum logic [1:0] {
		BPCM_IDLE = 2'b00,
		BPCM_EXEC = 2'b01,
		BPCM_CODE = 2'b10
	} bpcm_state_t;
endpackage

/* File: bpcm_code_addr.sv */
// Code-byte address adder: accumulator plus pointer or advanced counter
`timescale 1ns/100ps
module bpcm_code_addr (
	sel_pc,
	acc,
	data_pointer,
	pc,
	pc_next,
	addr
);
	import bpcm_pkg::*;
	input wire logic sel_pc;
	input wire logic [7:0] acc;
	input wire logic [15:0] data_pointer;
	input wire logic [15:0] pc;
	output logic [15:0] pc_next;
	output logic [15:0] addr;

	logic [15:0] base;

	// Counter moves past the one-byte opcode before it serves as base
	assign pc_next = pc + BPCM_LEN_ONE;
	// Pointer base is only read, never written back
	assign base = sel_pc ? pc_next : data_pointer;
	// Full 16-bit add so a low-byte carry ripples upward, unsigned acc
	assign addr = base + {8'h00, acc};
endmodule

/* File: bpcm_exec.sv */
// Decode and execute for indirect-immediate, bit, pointer-load and code-byte moves
// How it works
// - Opcode 0111011i stores immediate byte at address held by pointer; two bytes, one cycle.
// - Bit move copies source Boolean into destination bit location.
// - Only carry-to-bit and bit-to-carry moves exist; others are flagged unsupported.
// - Bit moves change nothing except the destination bit.
// - Opcode A2 plus bit address loads carry from bit; one cycle.
// - Opcode 92 plus bit address writes carry to bit; two cycles.
// - Pointer load is three bytes, two cycles, full 16 bits, no flags.
// - Second byte goes to high byte, third byte to low byte.
// - Code byte load puts program byte at acc plus base into acc.
// - Counter base is advanced first; pointer base stays unchanged.
// - Address uses full 16-bit add; flags untouched.
// - Opcode 93 code load via pointer is one byte, two cycles.
// - Opcode 83 code load via counter, one byte, two cycles, counter plus one.
`timescale 1ns/100ps
module bpcm_exec (
	clk,
	nrst,
	start,
	op_code,
	op_byte1,
	op_byte2,
	r0_value,
	r1_value,
	bit_in,
	carry_in,
	acc_in,
	pc_in,
	code_data,
	busy,
	done,
	unsupported,
	ram_we,
	ram_addr,
	ram_wdata,
	bit_we,
	bit_addr,
	bit_wdata,
	carry_we,
	carry_out,
	data_pointer,
	pc_we,
	pc_out,
	code_rd_en,
	code_addr,
	acc_we,
	acc_out
);
	import bpcm_pkg::*;
	input wire logic clk;
	input wire logic nrst;
	input wire logic start;
	input wire logic [7:0] op_code;
	input wire logic [7:0] op_byte1;
	input wire logic [7:0] op_byte2;
	input wire logic [7:0] r0_value;
	input wire logic [7:0] r1_value;
	input wire logic bit_in;
	input wire logic carry_in;
	input wire logic [7:0] acc_in;
	input wire logic [15:0] pc_in;
	input wire logic [7:0] code_data;
	output logic busy;
	output logic done;
	output logic unsupported;
	output logic ram_we;
	output logic [7:0] ram_addr;
	output logic [7:0] ram_wdata;
	output logic bit_we;
	output logic [7:0] bit_addr;
	output logic bit_wdata;
	output logic carry_we;
	output logic carry_out;
	output logic [15:0] data_pointer;
	output logic pc_we;
	output logic [15:0] pc_out;
	output logic code_rd_en;
	output logic [15:0] code_addr;
	output logic acc_we;
	output logic [7:0] acc_out;

	bpcm_state_t state_reg;
	bpcm_state_t state_next;
	logic [1:0] cyc_reg;
	logic [1:0] cyc_next;
	logic busy_reg;
	logic busy_next;
	logic done_reg;
	logic done_next;
	logic unsup_reg;
	logic unsup_next;
	logic ram_we_reg;
	logic ram_we_next;
	logic [7:0] ram_addr_reg;
	logic [7:0] ram_addr_next;
	logic [7:0] ram_wdata_reg;
	logic [7:0] ram_wdata_next;
	logic bit_we_reg;
	logic bit_we_next;
	logic [7:0] bit_addr_reg;
	logic [7:0] bit_addr_next;
	logic bit_wdata_reg;
	logic bit_wdata_next;
	logic carry_we_reg;
	logic carry_we_next;
	logic carry_reg;
	logic carry_next;
	logic [15:0] dp_reg;
	logic [15:0] dp_next;
	logic pc_we_reg;
	logic pc_we_next;
	logic [15:0] pc_reg;
	logic [15:0] pc_next;
	logic code_rd_reg;
	logic code_rd_next;
	logic [15:0] code_addr_reg;
	logic [15:0] code_addr_next;
	logic acc_we_reg;
	logic acc_we_next;
	logic [7:0] acc_reg;
	logic [7:0] acc_next;
	logic [15:0] pc_adv;
	logic [15:0] fetch_addr;
	logic is_ind_store;

	// Address of the code byte, formed at start from the live acc and counter inputs and the held pointer register
	bpcm_code_addr u_code_addr (
		.sel_pc(op_code == BPCM_OP_CODE_PC),
		.acc(acc_in),
		.data_pointer(dp_reg),
		.pc(pc_in),
		.pc_next(pc_adv),
		.addr(fetch_addr)
	);

	// Low opcode bit is masked off so both pointer variants match
	assign is_ind_store = (op_code & BPCM_OP_IND_MASK) == BPCM_OP_IND_STORE;

	// Next values: write strobes are single pulses, data holds until reused
	always_comb begin
		state_next = state_reg;
		cyc_next = cyc_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		unsup_next = 1'b0;
		ram_we_next = 1'b0;
		ram_addr_next = ram_addr_reg;
		ram_wdata_next = ram_wdata_reg;
		bit_we_next = 1'b0;
		bit_addr_next = bit_addr_reg;
		bit_wdata_next = bit_wdata_reg;
		carry_we_next = 1'b0;
		carry_next = carry_reg;
		dp_next = dp_reg;
		pc_we_next = 1'b0;
		pc_next = pc_reg;
		code_rd_next = 1'b0;
		code_addr_next = code_addr_reg;
		acc_we_next = 1'b0;
		acc_next = acc_reg;
		case (state_reg)
			BPCM_IDLE: begin
				// Starts are only taken while idle; a start while busy is dropped
				if (start) begin
					if (is_ind_store) begin
						ram_we_next = 1'b1;
						// Bank selection is already folded into r0/r1 by the core
						ram_addr_next = op_code[0] ? r1_value : r0_value;
						ram_wdata_next = op_byte1;
						done_next = 1'b1;
						cyc_next = BPCM_CYC_IND_STORE;
					end else if (op_code == BPCM_OP_BIT_TO_C) begin
						// Only carry changes; no other flag strobe is raised
						carry_we_next = 1'b1;
						carry_next = bit_in;
						done_next = 1'b1;
						cyc_next = BPCM_CYC_BIT_TO_C;
					end else if (op_code == BPCM_OP_C_TO_BIT) begin
						// Only the addressed bit is written
						bit_we_next = 1'b1;
						bit_addr_next = op_byte1;
						bit_wdata_next = carry_in;
						busy_next = 1'b1;
						state_next = BPCM_EXEC;
						cyc_next = BPCM_CYC_C_TO_BIT - 2'h1;
					end else if (op_code == BPCM_OP_DP_LOAD) begin
						// Whole pointer loaded at once, no carry strobe
						dp_next = {op_byte1, op_byte2};
						busy_next = 1'b1;
						state_next = BPCM_EXEC;
						cyc_next = BPCM_CYC_DP_LOAD - 2'h1;
					end else if (op_code == BPCM_OP_CODE_DP || op_code == BPCM_OP_CODE_PC) begin
						code_rd_next = 1'b1;
						code_addr_next = fetch_addr;
						// Counter write-back only for the counter-based form
						pc_we_next = op_code == BPCM_OP_CODE_PC;
						pc_next = pc_adv;
						busy_next = 1'b1;
						state_next = BPCM_CODE;
						cyc_next = BPCM_CYC_CODE - 2'h1;
					end else begin
						// Other bit pairings and foreign opcodes are not executed here
						unsup_next = 1'b1;
						done_next = 1'b1;
					end
				end
			end
			BPCM_EXEC: begin
				// Idle out the remaining machine cycle of the two-cycle carry-to-bit and pointer-load moves
				cyc_next = cyc_reg - 2'h1;
				if (cyc_reg == 2'h1) begin
					busy_next = 1'b0;
					done_next = 1'b1;
					state_next = BPCM_IDLE;
				end
			end
			BPCM_CODE: begin
				// Code byte answers combinationally in the cycle the read strobe is high; flags left alone
				acc_we_next = 1'b1;
				acc_next = code_data;
				cyc_next = cyc_reg - 2'h1;
				busy_next = 1'b0;
				done_next = 1'b1;
				state_next = BPCM_IDLE;
			end
			default: begin
				busy_next = 1'b0;
				state_next = BPCM_IDLE;
			end
		endcase
	end

	// Registers only; reset gives constants everywhere
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= BPCM_IDLE;
			cyc_reg <= 2'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			unsup_reg <= 1'b0;
			ram_we_reg <= 1'b0;
			ram_addr_reg <= BPCM_BYTE_RESET;
			ram_wdata_reg <= BPCM_BYTE_RESET;
			bit_we_reg <= 1'b0;
			bit_addr_reg <= BPCM_BYTE_RESET;
			bit_wdata_reg <= 1'b0;
			carry_we_reg <= 1'b0;
			carry_reg <= 1'b0;
			dp_reg <= BPCM_DP_RESET;
			pc_we_reg <= 1'b0;
			pc_reg <= BPCM_ADDR_RESET;
			code_rd_reg <= 1'b0;
			code_addr_reg <= BPCM_ADDR_RESET;
			acc_we_reg <= 1'b0;
			acc_reg <= BPCM_BYTE_RESET;
		end else begin
			state_reg <= state_next;
			cyc_reg <= cyc_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			unsup_reg <= unsup_next;
			ram_we_reg <= ram_we_next;
			ram_addr_reg <= ram_addr_next;
			ram_wdata_reg <= ram_wdata_next;
			bit_we_reg <= bit_we_next;
			bit_addr_reg <= bit_addr_next;
			bit_wdata_reg <= bit_wdata_next;
			carry_we_reg <= carry_we_next;
			carry_reg <= carry_next;
			dp_reg <= dp_next;
			pc_we_reg <= pc_we_next;
			pc_reg <= pc_next;
			code_rd_reg <= code_rd_next;
			code_addr_reg <= code_addr_next;
			acc_we_reg <= acc_we_next;
			acc_reg <= acc_next;
		end
	end

	// Every output straight from a flip-flop
	assign busy = busy_reg;
	assign done = done_reg;
	assign unsupported = unsup_reg;
	assign ram_we = ram_we_reg;
	assign ram_addr = ram_addr_reg;
	assign ram_wdata = ram_wdata_reg;
	assign bit_we = bit_we_reg;
	assign bit_addr = bit_addr_reg;
	assign bit_wdata = bit_wdata_reg;
	assign carry_we = carry_we_reg;
	assign carry_out = carry_reg;
	assign data_pointer = dp_reg;
	assign pc_we = pc_we_reg;
	assign pc_out = pc_reg;
	assign code_rd_en = code_rd_reg;
	assign code_addr = code_addr_reg;
	assign acc_we = acc_we_reg;
	assign acc_out = acc_reg;
endmodule

/* File: bpcm_exec_props.sv */
// Timing and value checker for the bit, pointer and code-byte move executor
`timescale 1ns/100ps
module bpcm_exec_props (
	clk,
	nrst,
	start,
	bit_in,
	carry_in,
	busy,
	done,
	unsupported,
	ram_we,
	bit_we,
	bit_wdata,
	carry_we,
	carry_out,
	pc_we,
	code_rd_en,
	acc_we,
	op_code,
	op_byte1,
	op_byte2,
	r0_value,
	r1_value,
	acc_in,
	code_data,
	ram_addr,
	ram_wdata,
	bit_addr,
	acc_out,
	pc_in,
	data_pointer,
	pc_out,
	code_addr
);
	input wire logic clk;
	input wire logic nrst;
	input wire logic start;
	input wire logic bit_in;
	input wire logic carry_in;
	input wire logic busy;
	input wire logic done;
	input wire logic unsupported;
	input wire logic ram_we;
	input wire logic bit_we;
	input wire logic bit_wdata;
	input wire logic carry_we;
	input wire logic carry_out;
	input wire logic pc_we;
	input wire logic code_rd_en;
	input wire logic acc_we;
	input wire logic [7:0] op_code;
	input wire logic [7:0] op_byte1;
	input wire logic [7:0] op_byte2;
	input wire logic [7:0] r0_value;
	input wire logic [7:0] r1_value;
	input wire logic [7:0] acc_in;
	input wire logic [7:0] code_data;
	input wire logic [7:0] ram_addr;
	input wire logic [7:0] ram_wdata;
	input wire logic [7:0] bit_addr;
	input wire logic [7:0] acc_out;
	input wire logic [15:0] pc_in;
	input wire logic [15:0] data_pointer;
	input wire logic [15:0] pc_out;
	input wire logic [15:0] code_addr;

	logic take;
	logic two;
	logic ind;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Busy is sampled high only on the edge after the taking edge of a two-cycle move, exactly while starts are refused
	assign take = start && !busy;
	assign two = op_code inside {8'h92, 8'h90, 8'h93, 8'h83};
	assign ind = op_code[7:1] == 7'h3B;
	a_store_data: assert property (take && ind |-> ##1 ram_we && done && ram_wdata == $past(op_byte1))
		else $error("indirect store data wrong");
	a_store_pointer: assert property (take && ind |-> ##1
		ram_addr == (($past(op_code) == 8'h77) ? $past(r1_value) : $past(r0_value)))
		else $error("indirect store address wrong");
	a_bit_to_carry: assert property (take && op_code == 8'hA2 |-> ##1
		carry_we && done && !bit_we && carry_out == $past(bit_in))
		else $error("carry load wrong");
	a_carry_to_bit: assert property (take && op_code == 8'h92 |-> ##1 bit_we && !done && !carry_we &&
		bit_wdata == $past(carry_in) && bit_addr == $past(op_byte1) ##1 done && !busy)
		else $error("bit store wrong");
	a_pointer_load: assert property (take && op_code == 8'h90 |-> ##1 busy &&
		data_pointer == {$past(op_byte1), $past(op_byte2)} ##1 done && $stable(data_pointer))
		else $error("pointer load wrong");
	a_code_pointer: assert property (take && op_code == 8'h93 |-> ##1 code_rd_en && !pc_we &&
		code_addr == $past(data_pointer) + {8'h00, $past(acc_in)} ##1 acc_we && done && acc_out == $past(code_data))
		else $error("pointer code read wrong");
	a_code_counter: assert property (take && op_code == 8'h83 |-> ##1 code_rd_en && pc_we &&
		pc_out == $past(pc_in) + 16'h0001 && code_addr == $past(pc_in) + 16'h0001 + {8'h00, $past(acc_in)})
		else $error("counter code read wrong");
	a_refuse_unknown: assert property (take && !(ind || two || op_code == 8'hA2) |-> ##1 done && unsupported &&
		!ram_we && !bit_we && !carry_we && !busy)
		else $error("unknown opcode not refused");
endmodule
bind bpcm_exec bpcm_exec_props u_props (.clk, .nrst, .start, .bit_in, .carry_in, .busy, .done, .unsupported, .ram_we,
	.bit_we, .bit_wdata, .carry_we, .carry_out, .pc_we, .code_rd_en, .acc_we, .op_code, .op_byte1, .op_byte2, .r0_value,
	.r1_value, .acc_in, .code_data, .ram_addr, .ram_wdata, .bit_addr, .acc_out, .pc_in, .data_pointer, .pc_out, .code_addr);

/* File: bpcm_code_mem.sv */
// Program memory model answering code-byte reads
`timescale 1ns/100ps
module bpcm_code_mem (
	clk,
	nrst,
	code_rd_en,
	code_addr,
	code_data
);
	input wire logic clk;
	input wire logic nrst;
	input wire logic code_rd_en;
	input wire logic [15:0] code_addr;
	output logic [7:0] code_data;
	logic [7:0] last_reg;
	// Idle bus shows the inverse of the last byte, so stale data never passes
	always_comb begin
		code_data = code_rd_en ? (code_addr[15:8] ^ code_addr[7:0] ^ 8'h5A) : ~last_reg;
	end
	// Remember what was last on the bus
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last_reg <= 8'h00;
		end else begin
			last_reg <= code_data;
		end
	end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the bit, pointer and code-byte move executor
`timescale 1ns/100ps
module tb_top;
	import bpcm_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, start = 1'b0, bit_in = 1'b0, carry_in = 1'b0;
	logic [7:0] op_code = 8'h00, op_byte1 = 8'h00, op_byte2 = 8'h00, r0_value = 8'h00, r1_value = 8'h00, acc_in = 8'h00;
	logic [15:0] pc_in = 16'h0000;
	logic [7:0] code_data, ram_addr, ram_wdata, bit_addr, acc_out;
	logic busy, done, unsupported, ram_we, bit_we, bit_wdata, carry_we, carry_out, pc_we, code_rd_en, acc_we;
	logic [15:0] data_pointer, pc_out, code_addr, exp_dp, ea;
	int fail_count = 0, tests_run = 0, n;
	logic [7:0] ops [9] = '{8'h76, 8'h77, 8'hA2, 8'h92, 8'h90, 8'h93, 8'h83, 8'hB2, 8'h85};
	// Free-running machine-cycle clock
	always #5 clk = ~clk;
	bpcm_exec dut (.clk, .nrst, .start, .op_code, .op_byte1, .op_byte2, .r0_value, .r1_value, .bit_in, .carry_in, .acc_in,
		.pc_in, .code_data, .busy, .done, .unsupported, .ram_we, .ram_addr, .ram_wdata, .bit_we, .bit_addr, .bit_wdata,
		.carry_we, .carry_out, .data_pointer, .pc_we, .pc_out, .code_rd_en, .code_addr, .acc_we, .acc_out);
	bpcm_code_mem mem (.clk, .nrst, .code_rd_en, .code_addr, .code_data);
	function automatic logic [7:0] rom(input logic [15:0] a);
		return a[15:8] ^ a[7:0] ^ 8'h5A;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("Counts: %0d compared, %0d mismatched", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One instruction: present bytes for one cycle, wait for done, compare held results
	task automatic run_op(input logic [7:0] op, input logic [7:0] acc);
		@(posedge clk);
		start <= 1'b1;
		op_code <= op;
		acc_in <= acc;
		{op_byte1, op_byte2, r0_value, r1_value} <= $urandom;
		{pc_in, bit_in, carry_in} <= 18'($urandom);
		@(posedge clk);
		start <= 1'b0;
		// Done of a one-cycle move stands at the taking edge itself, so look right after that edge first
		#1;
		n = 1;
		while (done !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(16'(n), (op inside {8'h76, 8'h77, 8'hA2, 8'hB2, 8'h85}) ? 16'h0001 : 16'h0002);
		chk(16'(unsupported), 16'(op inside {8'hB2, 8'h85}));
		case (op)
			8'h76, 8'h77: begin
				chk(16'(ram_addr), 16'(op[0] ? r1_value : r0_value));
				chk(16'(ram_wdata), 16'(op_byte1));
			end
			8'hA2: chk(16'(carry_out), 16'(bit_in));
			8'h92: begin
				chk(16'(bit_addr), 16'(op_byte1));
				chk(16'(bit_wdata), 16'(carry_in));
			end
			8'h90: exp_dp = {op_byte1, op_byte2};
			8'h93, 8'h83: begin
				ea = ((op == 8'h93) ? exp_dp : pc_in + 16'h0001) + 16'(acc);
				chk(code_addr, ea);
				chk(16'(acc_out), 16'(rom(ea)));
				if (op == 8'h83) chk(pc_out, pc_in + 16'h0001);
			end
			default: ;
		endcase
		chk(data_pointer, exp_dp);
	endtask
	// Main sequence: every opcode with a carry-heavy accumulator, then random mix
	initial begin
		void'($urandom(32'h65AE));
		exp_dp = BPCM_DP_RESET;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		foreach (ops[i]) run_op(ops[i], 8'hFF);
		repeat (80) run_op(ops[$urandom_range(8)], 8'($urandom));
		give_verdict();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		give_verdict();
	end
endmodule
